// ### hdl/isa_attribute_id_regs.sv
/*
  Instruction-set attribute identification registers 0 and 1 with
  privilege trap decision and authentication configuration effects.
  Assumes requests come from logic on clk, one at a time.
*/
`timescale 1ns/1ps
module isa_attribute_id_regs #(
  parameter bit cipher_ext_param = 1'b1,
  parameter logic [63:0] isa0_upper_value = 64'h0,
  parameter logic [63:0] isa1_value = isa_id_pkg::isa1_default
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cipher_ext_off_input,
  input wire logic read_valid,
  input wire logic write_valid,
  input wire logic [1:0] sel_op0,
  input wire logic [2:0] sel_op1,
  input wire logic [3:0] sel_crn,
  input wire logic [3:0] sel_crm,
  input wire logic [2:0] sel_op2,
  input wire isa_id_pkg::privilege_t current_privilege_level,
  input wire logic el2_enabled,
  input wire logic host_trap_general_bit,
  input wire logic id_group_trap_bit,
  output logic read_ready,
  output logic read_done,
  output logic write_done,
  output logic [63:0] read_data,
  output logic read_unmapped,
  output logic trap_taken,
  output isa_id_pkg::privilege_t trap_target_level,
  output logic [5:0] trap_syndrome_class,
  output logic tag_byte_data_only_bit_res0,
  output logic ptr_auth_keys_allocated,
  output logic ptr_auth_enable_bit_res0,
  output logic key_access_trap_bit_res0
);
  import isa_id_pkg::*;

  localparam logic [3:0] instr_auth_arch_field = isa1_value[instr_auth_arch_lsb +: 4];
  localparam logic [3:0] instr_auth_impdef_field = isa1_value[instr_auth_impdef_lsb +: 4];
  localparam logic [3:0] generic_auth_arch_field = isa1_value[generic_auth_arch_lsb +: 4];
  localparam logic [3:0] generic_auth_impdef_field = isa1_value[generic_auth_impdef_lsb +: 4];
  localparam bit instr_auth_none = (instr_auth_arch_field == 4'h0) &&
                                   (instr_auth_impdef_field == 4'h0);
  localparam bit all_auth_none = instr_auth_none && (generic_auth_arch_field == 4'h0) &&
                                 (generic_auth_impdef_field == 4'h0);

  logic sampled_off;
  logic sampled_valid;
  logic cipher_active;
  logic cfg_done;
  logic [63:0] isa0_value;
  logic [63:0] next_isa0;
  logic id_space;
  logic hit0;
  logic hit1;
  logic take;
  logic next_trap;
  privilege_t next_target;

  cipher_strap_sync strap (
    .clk(clk),
    .rstn(rstn),
    .cipher_ext_off_input(cipher_ext_off_input),
    .sampled_off(sampled_off),
    .sampled_valid(sampled_valid)
  );

  // ==========================================================
  // Cipher configuration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cipher_active <= 1'b0;
    end else if (sampled_valid) begin
      cipher_active <= cipher_ext_param && !sampled_off;
    end
  end

  // Reads held off until register 0 holds the captured strap, so no early value leaks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_done <= 1'b0;
      read_ready <= 1'b0;
    end else begin
      cfg_done <= sampled_valid;
      read_ready <= cfg_done;
    end
  end

  // ==========================================================
  // Register 0 contents
  always_comb begin
    next_isa0 = isa0_upper_value & isa0_upper_mask;
    next_isa0[checksum_lsb +: 4] = checksum_val;
    next_isa0[hash_long_lsb +: 4] = cipher_active ? hash_long_on : field_off;
    next_isa0[hash_short_lsb +: 4] = cipher_active ? hash_short_on : field_off;
    next_isa0[block_cipher_lsb +: 4] = cipher_active ? block_cipher_on : field_off;
  end

  // No write path: contents depend only on the frozen strap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      isa0_value <= isa0_reset;
    end else begin
      isa0_value <= next_isa0;
    end
  end

  // ==========================================================
  // Access decode and trap decision
  assign id_space = sel_op0 == sel_op0_id && sel_op1 == sel_op1_id &&
                    sel_crn == sel_crn_id && sel_crm == sel_crm_id;
  assign hit0 = id_space && sel_op2 == sel_op2_isa0;
  assign hit1 = id_space && sel_op2 == sel_op2_isa1;
  assign take = read_valid && read_ready;

  always_comb begin
    next_trap = 1'b0;
    next_target = lvl_kernel;
    unique case (current_privilege_level)
      lvl_user: begin
        next_trap = 1'b1;
        next_target = (el2_enabled && host_trap_general_bit) ? lvl_hyp : lvl_kernel;
      end
      lvl_kernel: begin
        next_trap = el2_enabled && id_group_trap_bit;
        next_target = lvl_hyp;
      end
      lvl_hyp, lvl_monitor: begin
        next_trap = 1'b0;
        next_target = lvl_kernel;
      end
    endcase
  end

  // ==========================================================
  // Response
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_done <= 1'b0;
      read_unmapped <= 1'b0;
      trap_taken <= 1'b0;
      trap_target_level <= lvl_kernel;
      trap_syndrome_class <= 6'h0;
    end else begin
      read_done <= take;
      read_unmapped <= take && !hit0 && !hit1;
      trap_taken <= take && (hit0 || hit1) && next_trap;
      trap_target_level <= take ? next_target : lvl_kernel;
      trap_syndrome_class <= (take && (hit0 || hit1) && next_trap) ? id_trap_class : 6'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_data <= 64'h0;
    end else if (take && !next_trap && hit0) begin
      read_data <= isa0_value;
    end else if (take && !next_trap && hit1) begin
      read_data <= isa1_value;
    end else begin
      read_data <= 64'h0;
    end
  end

  // Writes are acknowledged and dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_done <= 1'b0;
    end else begin
      write_done <= write_valid;
    end
  end

  // ==========================================================
  // Authentication configuration effects
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tag_byte_data_only_bit_res0 <= instr_auth_none;
      ptr_auth_keys_allocated <= !instr_auth_none;
      ptr_auth_enable_bit_res0 <= instr_auth_none;
      key_access_trap_bit_res0 <= all_auth_none;
    end else begin
      tag_byte_data_only_bit_res0 <= instr_auth_none;
      ptr_auth_keys_allocated <= !instr_auth_none;
      ptr_auth_enable_bit_res0 <= instr_auth_none;
      key_access_trap_bit_res0 <= all_auth_none;
    end
  end

  // ==========================================================
  // Checks
  property p_checksum;
    @(posedge clk) disable iff (!rstn)
    $past(take && hit0 && !next_trap) |-> read_data[checksum_lsb +: 4] == 4'h1;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum field wrong");

  property p_hash_long;
    @(posedge clk) disable iff (!rstn)
    $past(take && hit0 && !next_trap) |->
      read_data[hash_long_lsb +: 4] == (cipher_active ? 4'h2 : 4'h0);
  endproperty
  a_hash_long: assert property (p_hash_long) else $error("long hash field wrong");

  property p_hash_short;
    @(posedge clk) disable iff (!rstn)
    $past(take && hit0 && !next_trap) |->
      read_data[hash_short_lsb +: 4] == (cipher_active ? 4'h1 : 4'h0);
  endproperty
  a_hash_short: assert property (p_hash_short) else $error("short hash field wrong");

  property p_block_cipher;
    @(posedge clk) disable iff (!rstn)
    $past(take && hit0 && !next_trap) |->
      read_data[block_cipher_lsb +: 4] == (cipher_active ? 4'h2 : 4'h0);
  endproperty
  a_block_cipher: assert property (p_block_cipher) else $error("cipher field wrong");

  property p_cipher_cfg;
    @(posedge clk) disable iff (!rstn)
    read_ready |-> cipher_active == (cipher_ext_param && !sampled_off);
  endproperty
  a_cipher_cfg: assert property (p_cipher_cfg) else $error("cipher state wrong");

  property p_user_trap;
    @(posedge clk) disable iff (!rstn)
    take && (hit0 || hit1) && current_privilege_level == lvl_user |=> trap_taken &&
      trap_syndrome_class == 6'h18 && read_data == 64'h0 &&
      trap_target_level == ($past(el2_enabled && host_trap_general_bit) ? lvl_hyp : lvl_kernel);
  endproperty
  a_user_trap: assert property (p_user_trap) else $error("user read not trapped");

  property p_kernel_read;
    @(posedge clk) disable iff (!rstn)
    take && hit0 && current_privilege_level == lvl_kernel |=>
      trap_taken == $past(el2_enabled && id_group_trap_bit) &&
      (trap_taken ? trap_target_level == lvl_hyp : read_data == isa0_value);
  endproperty
  a_kernel_read: assert property (p_kernel_read) else $error("kernel read wrong");

  property p_high_read;
    @(posedge clk) disable iff (!rstn)
    take && hit0 && current_privilege_level inside {lvl_hyp, lvl_monitor} |=>
      !trap_taken && read_done && read_data == isa0_value;
  endproperty
  a_high_read: assert property (p_high_read) else $error("high level read trapped");

  property p_isa1_read;
    @(posedge clk) disable iff (!rstn)
    $past(take && hit1 && !next_trap) |-> read_data == isa1_value;
  endproperty
  a_isa1_read: assert property (p_isa1_read) else $error("register 1 value wrong");

  property p_auth_effects;
    @(posedge clk) disable iff (!rstn)
    tag_byte_data_only_bit_res0 == (isa1_value[instr_auth_arch_lsb +: 8] == 8'h0) &&
      key_access_trap_bit_res0 == (isa1_value[instr_auth_arch_lsb +: 8] == 8'h0 &&
      isa1_value[generic_auth_arch_lsb +: 8] == 8'h0) &&
      ptr_auth_keys_allocated != tag_byte_data_only_bit_res0 &&
      ptr_auth_enable_bit_res0 == tag_byte_data_only_bit_res0;
  endproperty
  a_auth_effects: assert property (p_auth_effects) else $error("auth effects inconsistent");

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
    (isa0_value & isa0_res0_mask) == 64'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_constant;
    @(posedge clk) disable iff (!rstn)
    read_ready && $past(read_ready) |-> $stable(isa0_value);
  endproperty
  a_constant: assert property (p_constant) else $error("register 0 changed");
endmodule : isa_attribute_id_regs

// ### pkg/isa_id_pkg.sv
/*
  Constants, field layout and types for the instruction-set attribute
  identification registers. Assumes one core clock and one core reset.
*/
// Notes on behaviour
// - Bits 19:16 of attribute register 0 read 0001: all checksum instructions present.
// - Bits 15:12 read 0010 with cipher extensions active, otherwise zero.
// - Bits 11:8 read 0001 with cipher extensions active, otherwise zero.
// - Bits 7:4 read 0010 with cipher extensions active, otherwise zero.
// - Cipher active only if configured and the disable input is low at reset.
// - Register 0 is selected by op0 11, op1 000, CRn 0000, CRm 0110, op2 000.
// - User-level reads trap class 0x18, to hypervisor if enabled and host trap bit, else kernel.
// - Kernel reads trap to hypervisor when enabled and ID trap bit set, else return.
// - Hypervisor and monitor reads always return the value without trapping.
// - Attribute register 1 is 64 bits, identification group, reports features.
// - Instruction auth fields both zero: tag-byte bits, keys, enables become reserved.
// - All four auth fields zero: key-access and auth trap bits become reserved.
// - Bits 63:60, 27:24 and 3:0 of register 0 are reserved and read zero.
package isa_id_pkg;
  typedef enum logic [1:0] {
    lvl_user = 2'b00,
    lvl_kernel = 2'b01,
    lvl_hyp = 2'b10,
    lvl_monitor = 2'b11
  } privilege_t;

  // ==========================================================
  // Register selection encodings
  localparam logic [1:0] sel_op0_id = 2'h3;
  localparam logic [2:0] sel_op1_id = 3'h0;
  localparam logic [3:0] sel_crn_id = 4'h0;
  localparam logic [3:0] sel_crm_id = 4'h6;
  localparam logic [2:0] sel_op2_isa0 = 3'h0;
  localparam logic [2:0] sel_op2_isa1 = 3'h1;

  // ==========================================================
  // Register 0 fields
  localparam int checksum_lsb = 16;
  localparam int hash_long_lsb = 12;
  localparam int hash_short_lsb = 8;
  localparam int block_cipher_lsb = 4;
  localparam logic [3:0] field_off = 4'h0;
  localparam logic [3:0] checksum_val = 4'h1;
  localparam logic [3:0] hash_long_on = 4'h2;
  localparam logic [3:0] hash_short_on = 4'h1;
  localparam logic [3:0] block_cipher_on = 4'h2;
  localparam logic [63:0] isa0_upper_mask = 64'h0fff_ffff_f0f0_0000;
  localparam logic [63:0] isa0_res0_mask = 64'hf000_0000_0f00_000f;
  localparam logic [63:0] isa0_reset = 64'h0;

  // ==========================================================
  // Register 1 authentication fields
  localparam int instr_auth_arch_lsb = 4;
  localparam int instr_auth_impdef_lsb = 8;
  localparam int generic_auth_arch_lsb = 24;
  localparam int generic_auth_impdef_lsb = 28;
  localparam logic [63:0] isa1_default = 64'h0000_0000_0100_0000;

  // ==========================================================
  // Trap and timing
  localparam logic [5:0] id_trap_class = 6'h18;
  localparam logic [1:0] strap_settle_cycles = 2'h3;
endpackage : isa_id_pkg

// ### hdl/cipher_strap_sync.sv
/*
  Samples the cipher disable pin once after reset release.
  Assumes the pin is asynchronous and static around reset.
*/
`timescale 1ns/1ps
module cipher_strap_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cipher_ext_off_input,
  output logic sampled_off,
  output logic sampled_valid
);
  import isa_id_pkg::*;

  logic s1;
  logic s2;
  logic s3;
  logic [1:0] settle;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= cipher_ext_off_input;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================
  // One-time capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle <= 2'h0;
    end else if (settle != strap_settle_cycles) begin
      settle <= settle + 2'h1;
    end
  end

  // Waits for the chain to fill, then freezes until next reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sampled_off <= 1'b1;
      sampled_valid <= 1'b0;
    end else if (!sampled_valid && settle == strap_settle_cycles && s2 == s3) begin
      sampled_off <= s3;
      sampled_valid <= 1'b1;
    end
  end

  property p_strap_frozen;
    @(posedge clk) disable iff (!rstn)
    $past(sampled_valid) |-> $stable(sampled_off);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed after capture");
endmodule : cipher_strap_sync

// ### verification/tb_top.sv
/*
  Self-checking bench for the attribute identification registers.
  Assumes the package and both design files are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import isa_id_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cipher_ext_off_input = 1'b0;
  logic read_valid = 1'b0;
  logic write_valid = 1'b0;
  logic [1:0] sel_op0 = sel_op0_id;
  logic [2:0] sel_op1 = sel_op1_id;
  logic [3:0] sel_crn = sel_crn_id;
  logic [3:0] sel_crm = sel_crm_id;
  logic [2:0] sel_op2 = sel_op2_isa0;
  privilege_t current_privilege_level = lvl_hyp;
  logic el2_enabled = 1'b0;
  logic host_trap_general_bit = 1'b0;
  logic id_group_trap_bit = 1'b0;
  logic read_ready, read_done, write_done, read_unmapped, trap_taken;
  logic [63:0] read_data;
  privilege_t trap_target_level;
  logic [5:0] trap_syndrome_class;
  logic tb_res0, keys_alloc, en_res0, key_res0;
  logic alt_ready;
  logic [63:0] alt_data;
  logic alt_tb_res0, alt_keys, alt_en_res0, alt_key_res0;
  int n_errors = 0;
  int n_tests = 0;

  isa_attribute_id_regs isa_attribute_id_regs_i (
    .clk(clk), .rstn(rstn), .cipher_ext_off_input(cipher_ext_off_input),
    .read_valid(read_valid), .write_valid(write_valid), .sel_op0(sel_op0),
    .sel_op1(sel_op1), .sel_crn(sel_crn), .sel_crm(sel_crm), .sel_op2(sel_op2),
    .current_privilege_level(current_privilege_level), .el2_enabled(el2_enabled),
    .host_trap_general_bit(host_trap_general_bit), .id_group_trap_bit(id_group_trap_bit),
    .read_ready(read_ready), .read_done(read_done), .write_done(write_done),
    .read_data(read_data), .read_unmapped(read_unmapped), .trap_taken(trap_taken),
    .trap_target_level(trap_target_level), .trap_syndrome_class(trap_syndrome_class),
    .tag_byte_data_only_bit_res0(tb_res0), .ptr_auth_keys_allocated(keys_alloc),
    .ptr_auth_enable_bit_res0(en_res0), .key_access_trap_bit_res0(key_res0)
  );

  // Second build: cipher not configured, no authentication fields at all
  isa_attribute_id_regs #(
    .cipher_ext_param(1'b0),
    .isa1_value(64'h0)
  ) alt_isa_attribute_id_regs_i (
    .clk(clk), .rstn(rstn), .cipher_ext_off_input(cipher_ext_off_input),
    .read_valid(read_valid), .write_valid(write_valid), .sel_op0(sel_op0),
    .sel_op1(sel_op1), .sel_crn(sel_crn), .sel_crm(sel_crm), .sel_op2(sel_op2),
    .current_privilege_level(current_privilege_level), .el2_enabled(el2_enabled),
    .host_trap_general_bit(host_trap_general_bit), .id_group_trap_bit(id_group_trap_bit),
    .read_ready(alt_ready), .read_done(), .write_done(), .read_data(alt_data),
    .read_unmapped(), .trap_taken(), .trap_target_level(), .trap_syndrome_class(),
    .tag_byte_data_only_bit_res0(alt_tb_res0), .ptr_auth_keys_allocated(alt_keys),
    .ptr_auth_enable_bit_res0(alt_en_res0), .key_access_trap_bit_res0(alt_key_res0)
  );

  always #4 clk = ~clk;

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [63:0] exp_isa0(input logic on);
    logic [63:0] v;
    v = 64'h0;
    v[checksum_lsb +: 4] = checksum_val;
    v[hash_long_lsb +: 4] = on ? hash_long_on : field_off;
    v[hash_short_lsb +: 4] = on ? hash_short_on : field_off;
    v[block_cipher_lsb +: 4] = on ? block_cipher_on : field_off;
    return v;
  endfunction : exp_isa0

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Reset for 6 cycles, then poll read_ready so no read is refused
  task automatic do_reset(input logic off);
    int i;
    @(posedge clk);
    #1;
    rstn = 1'b0;
    cipher_ext_off_input = off;
    repeat (6) @(posedge clk);
    chk("read_done in reset", 64'h0, {63'h0, read_done});
    chk("read_data in reset", 64'h0, read_data);
    #1;
    rstn = 1'b1;
    for (i = 0; i < 20 && read_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("read_ready", 64'h1, {63'h0, read_ready});
    chk("alt read_ready", 64'h1, {63'h0, alt_ready});
  endtask : do_reset

  task automatic do_read(input logic [2:0] op2, input logic [3:0] crm, input privilege_t lvl,
                         input logic e2, input logic host_bit, input logic group_bit);
    @(posedge clk);
    #1;
    sel_op2 = op2;
    sel_crm = crm;
    current_privilege_level = lvl;
    el2_enabled = e2;
    host_trap_general_bit = host_bit;
    id_group_trap_bit = group_bit;
    read_valid = 1'b1;
    @(posedge clk);
    #1;
    read_valid = 1'b0;
    chk("read_done", 64'h1, {63'h0, read_done});
  endtask : do_read

  // ==========================================================
  // Scenarios
  task automatic t_auth_levels;
    chk("tag byte res0", 64'h1, {63'h0, tb_res0});
    chk("keys allocated", 64'h0, {63'h0, keys_alloc});
    chk("enable res0", 64'h1, {63'h0, en_res0});
    chk("key access res0", 64'h0, {63'h0, key_res0});
    chk("alt tag byte res0", 64'h1, {63'h0, alt_tb_res0});
    chk("alt keys allocated", 64'h0, {63'h0, alt_keys});
    chk("alt enable res0", 64'h1, {63'h0, alt_en_res0});
    chk("alt key access res0", 64'h1, {63'h0, alt_key_res0});
  endtask : t_auth_levels

  task automatic t_read_values(input logic on);
    do_read(sel_op2_isa0, sel_crm_id, lvl_hyp, 1'b1, 1'b1, 1'b1);
    chk("isa0 value", exp_isa0(on), read_data);
    chk("isa0 no trap", 64'h0, {63'h0, trap_taken});
    chk("alt isa0 value", exp_isa0(1'b0), alt_data);
    do_read(sel_op2_isa1, sel_crm_id, lvl_monitor, 1'b1, 1'b1, 1'b1);
    chk("isa1 value", isa1_default, read_data);
    chk("alt isa1 value", 64'h0, alt_data);
  endtask : t_read_values

  task automatic t_traps;
    privilege_t lv [8] = '{lvl_user, lvl_user, lvl_user, lvl_kernel,
                           lvl_kernel, lvl_kernel, lvl_hyp, lvl_monitor};
    logic [7:0] e2 = 8'hee;
    logic [7:0] tg = 8'he3;
    logic [7:0] t3 = 8'hdc;
    logic [7:0] tr = 8'h0f;
    logic [7:0] to_hyp = 8'h0a;
    int i;
    for (i = 0; i < 8; i++) begin
      do_read(sel_op2_isa0, sel_crm_id, lv[i], e2[i], tg[i], t3[i]);
      chk("trap taken", {63'h0, tr[i]}, {63'h0, trap_taken});
      chk("trap class", tr[i] ? 64'(id_trap_class) : 64'h0, 64'(trap_syndrome_class));
      chk("read data", tr[i] ? 64'h0 : exp_isa0(1'b1), read_data);
      if (tr[i]) begin
        chk("trap target", to_hyp[i] ? 64'(lvl_hyp) : 64'(lvl_kernel),
            64'(trap_target_level));
      end
    end
  endtask : t_traps

  task automatic t_unmapped;
    do_read(sel_op2_isa0, 4'h7, lvl_hyp, 1'b0, 1'b0, 1'b0);
    chk("unmapped flag", 64'h1, {63'h0, read_unmapped});
    chk("unmapped data", 64'h0, read_data);
    do_read(sel_op2_isa0, sel_crm_id, lvl_hyp, 1'b0, 1'b0, 1'b0);
    chk("mapped flag", 64'h0, {63'h0, read_unmapped});
  endtask : t_unmapped

  task automatic t_write;
    @(posedge clk);
    #1;
    sel_op2 = sel_op2_isa0;
    write_valid = 1'b1;
    @(posedge clk);
    #1;
    write_valid = 1'b0;
    chk("write_done", 64'h1, {63'h0, write_done});
    do_read(sel_op2_isa0, sel_crm_id, lvl_kernel, 1'b0, 1'b0, 1'b0);
    chk("isa0 after write", exp_isa0(1'b1), read_data);
  endtask : t_write

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_auth_levels();
    t_read_values(1'b1);
    t_traps();
    t_unmapped();
    t_write();
    // Second reset mid-run with the disable pin high
    do_reset(1'b1);
    t_read_values(1'b0);
    t_auth_levels();
    do_reset(1'b0);
    t_read_values(1'b1);
    stop_test();
  end

  // Whole run is under a hundred cycles; the 5000-cycle limit allows ample margin
  initial begin
    #(8 * 5000);
    n_errors++;
    stop_test();
  end
endmodule : tb_top
